// ### design/rxq_top.sv
// Receive timeout stop logic, data modes and quality indicators
// Notes on behaviour
// - Three indicators may stop the timeout
// - Timeout expiry aborts and discards reception
// - AND select, no masks: never expires
// - OR select, no masks: always expires
// - Single mask: that indicator stops timer
// - AND select: all enabled indicators needed
// - OR select: any enabled indicator suffices
// - FIFO mode writes raw bytes continuously
// - GPIO mode: data changes on falling clock
// - Strength byte, dBm is code minus 146
// - Capture on sync, abort, expiry
// - Stream strength every 8 link clocks
// - Static sense with 3 dB hysteresis
// - Dynamic sense on 6/12/18 dB steps
// - Carrier sense starts downstream algorithms
// - Preamble count +1 inversion, -4 repetition
// - Preamble valid above four times limit
// - Sync valid at length minus twice limit
// - Sync readout: peak plus secondary flag
// - Blanking drops data below threshold
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module rxq_top
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Register port
    input wire logic [3:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    // Receiver state and commands
    input wire logic rx_active_in,
    input wire logic abort_command_in,
    // Demodulator side
    input wire logic [7:0] strength_in,
    input wire logic bit_valid_in,
    input wire logic bit_in,
    input wire logic sync_corr_valid_in,
    input wire logic [5:0] sync_corr_in,
    input wire logic sync_secondary_in,
    // Serial link pins
    input wire logic spi_sclk_in,
    input wire logic spi_csn_in,
    output logic spi_miso_out,
    output logic spi_miso_oe_out,
    // Direct data outputs
    output logic fifo_wr_out,
    output logic [7:0] fifo_data_out,
    output logic gpio_data_out,
    output logic gpio_clk_out,
    // Indicators and timer events
    output logic carrier_sense_out,
    output logic preamble_valid_out,
    output logic sync_valid_out,
    output logic rx_abort_out
);
    ////////////////////////////////////////////////////////////////////
    // Helpers
    // Saturating difference of two strengths
    function automatic logic [7:0] sat_sub(input logic [7:0] a,
                                           input logic [7:0] b);
        sat_sub = (a > b) ? 8'(a - b) : 8'h00;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Registers and decode
    rxq_pkg::rxq_ctrl_t ctrl_r; // Control word
    rxq_pkg::rxq_thresh_t thr_r; // Thresholds
    logic [15:0] tmo_load_r; // Timeout length in cycles
    logic [7:0] cap_r; // Strength at capture
    logic [7:0] pqi_r; // Preamble quality count
    logic [7:0] pqi_peak_r; // Running peak of it
    logic [5:0] sqi_peak_r; // Peak sync correlation
    logic sqi_sec_r; // Peak came from secondary word
    logic cs_r; // Carrier sense
    logic rx_prev_r; // Receive state last cycle
    rxq_pkg::rxq_tstate_t ts_r; // Timer state
    logic [15:0] tcnt_r; // Timer count
    wire wr_ctrl = reg_wr_in && reg_addr_in == rxq_pkg::REG_CTRL;
    wire wr_thr = reg_wr_in && reg_addr_in == rxq_pkg::REG_THRESH;
    wire wr_tmo = reg_wr_in && reg_addr_in == rxq_pkg::REG_TIMEOUT;
    wire rx_start = rx_active_in && !rx_prev_r;
    // Read mux, unmapped words read zero
    logic [31:0] rd_mux;
    always_comb
    begin
        unique case (reg_addr_in)
            rxq_pkg::REG_CTRL: rd_mux = 32'(ctrl_r);
            rxq_pkg::REG_THRESH: rd_mux = 32'(thr_r);
            rxq_pkg::REG_TIMEOUT: rd_mux = 32'(tmo_load_r);
            rxq_pkg::REG_STATUS:
                rd_mux = 32'({ts_r, sync_valid_out, preamble_valid_out,
                              cs_r});
            rxq_pkg::REG_STRENGTH: rd_mux = 32'({cap_r, strength_in});
            rxq_pkg::REG_QUALITY:
                rd_mux = 32'({sqi_sec_r, sqi_peak_r, pqi_peak_r});
            default: rd_mux = 32'h0000_0000;
        endcase
    end
    // Config writes; read data only in the cycle after the strobe
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            ctrl_r <= rxq_pkg::CTRL_RST;
            thr_r <= '{sync_word_length: rxq_pkg::SYNC_WORD_LENGTH_RST, default: '0};
            tmo_load_r <= rxq_pkg::TIMEOUT_RST;
            reg_rdata_out <= 32'h0000_0000;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_r <= rxq_pkg::rxq_ctrl_t'(reg_wdata_in[9:0]);
            if (wr_thr)
                thr_r <= rxq_pkg::rxq_thresh_t'(reg_wdata_in[20:0]);
            if (wr_tmo)
                tmo_load_r <= reg_wdata_in[15:0];
            reg_rdata_out <= reg_rd_in ? rd_mux : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Carrier sense, static and dynamic
    logic [7:0] lo_r; // Lowest strength while sense off
    logic [7:0] hi_r; // Highest strength while sense on
    wire [7:0] th = thr_r.strength_th;
    // Step is 6, 12 or 18 dB by mode
    wire [7:0] step = 8'(rxq_pkg::CS_STEP_DB * ctrl_r.cs_mode);
    wire above = strength_in > th;
    wire st_on = above;
    wire st_off = strength_in < sat_sub(th, rxq_pkg::CS_HYST_DB);
    wire dy_on = above && sat_sub(strength_in, lo_r) >= step;
    wire dy_off = sat_sub(hi_r, strength_in) >= step;
    wire static_m = ctrl_r.cs_mode == 2'h0;
    wire cs_set = static_m ? st_on : dy_on;
    wire cs_clr = static_m ? st_off : dy_off;
    // Sense flag; setting restarts the highest, clearing restarts the lowest
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            cs_r <= 1'b0;
            lo_r <= 8'hff;
            hi_r <= 8'h00;
        end
        else if (!cs_r && cs_set)
        begin
            cs_r <= 1'b1;
            hi_r <= strength_in;
        end
        else if (cs_r && cs_clr)
        begin
            cs_r <= 1'b0;
            lo_r <= strength_in;
        end
        else
        begin
            lo_r <= (strength_in < lo_r) ? strength_in : lo_r;
            hi_r <= (strength_in > hi_r) ? strength_in : hi_r;
        end
    end
    // Exported to the demodulator and the CSMA engine
    assign carrier_sense_out = cs_r;

    ////////////////////////////////////////////////////////////////////
    // Preamble and sync quality
    logic prev_bit_r; // Last accepted bit
    logic have_prev_r; // A previous bit exists
    wire inv = bit_valid_in && have_prev_r && bit_in != prev_bit_r;
    wire rep = bit_valid_in && have_prev_r && bit_in == prev_bit_r;
    wire [7:0] pqi_up = (pqi_r == rxq_pkg::PQI_MAX) ? pqi_r :
                        8'(pqi_r + rxq_pkg::PQI_UP);
    wire [7:0] pqi_nxt = inv ? pqi_up :
                         rep ? sat_sub(pqi_r, rxq_pkg::PQI_DOWN) : pqi_r;
    wire [7:0] preamble_quality_limit = 8'({thr_r.pqi_limit, 2'b00});
    wire [6:0] sqi_need = 7'(thr_r.sync_word_length) - 7'({thr_r.sqi_limit, 1'b0});
    wire pqi_ok = pqi_peak_r > preamble_quality_limit;
    wire sqi_ok = ctrl_r.sync_check_on && !sqi_need[6] &&
                  sqi_peak_r >= sqi_need[5:0];
    // Counters restart on each entry to receive
    always_ff @(posedge clk_in)
    begin
        if (rst_in || rx_start)
        begin
            pqi_r <= 8'h00;
            pqi_peak_r <= 8'h00;
            sqi_peak_r <= 6'h00;
            sqi_sec_r <= 1'b0;
            prev_bit_r <= 1'b0;
            have_prev_r <= 1'b0;
        end
        else
        begin
            pqi_r <= pqi_nxt;
            if (pqi_nxt > pqi_peak_r)
                pqi_peak_r <= pqi_nxt;
            if (bit_valid_in)
            begin
                prev_bit_r <= bit_in;
                have_prev_r <= 1'b1;
            end
            // Peak correlation and which word gave it
            if (sync_corr_valid_in && sync_corr_in > sqi_peak_r)
            begin
                sqi_peak_r <= sync_corr_in;
                sqi_sec_r <= sync_secondary_in;
            end
        end
    end
    // Valid flags as levels
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            preamble_valid_out <= 1'b0;
            sync_valid_out <= 1'b0;
        end
        else
        begin
            preamble_valid_out <= pqi_ok && !rx_start;
            sync_valid_out <= sqi_ok && !rx_start;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Receive timeout with stop condition
    wire [2:0] masks = {ctrl_r.pqi_mask, ctrl_r.sync_mask, ctrl_r.cs_mask};
    wire [2:0] inds = {pqi_ok, sqi_ok, cs_r};
    wire [2:0] hits = masks & inds;
    // No mask: AND never expires, OR cannot stop
    wire stop_cond = (|masks) ? (ctrl_r.combine_sel ? |hits
                                 : hits == masks)
                     : !ctrl_r.combine_sel;
    // Leaving receive wins over expiry, so no stray abort pulse
    wire expire = ts_r == rxq_pkg::T_RUN && rx_active_in && !stop_cond &&
                  tcnt_r == 16'h0000;
    // Timer state machine, checked every cycle of receive
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            ts_r <= rxq_pkg::T_IDLE;
            tcnt_r <= 16'h0000;
            rx_abort_out <= 1'b0;
            rx_prev_r <= 1'b0;
        end
        else
        begin
            rx_prev_r <= rx_active_in; // Entry edge finder
            rx_abort_out <= expire;
            unique case (ts_r)
                rxq_pkg::T_IDLE:
                    if (rx_start)
                    begin
                        ts_r <= rxq_pkg::T_RUN;
                        tcnt_r <= tmo_load_r;
                    end
                rxq_pkg::T_RUN:
                    if (!rx_active_in)
                        ts_r <= rxq_pkg::T_IDLE;
                    else if (stop_cond)
                        ts_r <= rxq_pkg::T_HALT;
                    else if (expire)
                        ts_r <= rxq_pkg::T_DONE;
                    else
                        tcnt_r <= tcnt_r - 16'h0001;
                rxq_pkg::T_HALT, rxq_pkg::T_DONE:
                    if (!rx_active_in)
                        ts_r <= rxq_pkg::T_IDLE;
                default:
                    ts_r <= rxq_pkg::T_IDLE;
            endcase
        end
    end
    // Capture on sync, abort command or expiry
    logic sync_prev_r;
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            cap_r <= 8'h00;
            sync_prev_r <= 1'b0;
        end
        else
        begin
            sync_prev_r <= sqi_ok;
            if ((sqi_ok && !sync_prev_r) || expire ||
                (abort_command_in && rx_active_in))
                cap_r <= strength_in;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Direct receive modes with blanking
    wire blanked = ctrl_r.blank_en && strength_in < th;
    wire take = bit_valid_in && rx_active_in && !blanked &&
                ts_r != rxq_pkg::T_DONE;
    logic [7:0] byte_r; // Byte under assembly
    logic [2:0] nbit_r; // Bits in it
    logic [3:0] glow_r; // Low phase countdown
    // FIFO mode: raw bytes, no packet processing
    always_ff @(posedge clk_in)
    begin
        if (rst_in || rx_start)
        begin
            byte_r <= 8'h00;
            nbit_r <= 3'h0;
            fifo_wr_out <= 1'b0;
            fifo_data_out <= 8'h00;
        end
        else
        begin
            fifo_wr_out <= 1'b0;
            if (take && ctrl_r.rx_mode == rxq_pkg::MODE_FIFO)
            begin
                byte_r <= {byte_r[6:0], bit_in};
                nbit_r <= nbit_r + 3'h1;
                if (nbit_r == 3'h7)
                begin
                    fifo_wr_out <= 1'b1;
                    fifo_data_out <= {byte_r[6:0], bit_in};
                end
            end
        end
    end
    // GPIO mode: data changes with falling clock, rises later
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            gpio_data_out <= 1'b0;
            gpio_clk_out <= 1'b1;
            glow_r <= 4'h0;
        end
        else if (take && ctrl_r.rx_mode == rxq_pkg::MODE_GPIO)
        begin
            gpio_data_out <= bit_in;
            gpio_clk_out <= 1'b0;
            glow_r <= rxq_pkg::GPIO_LOW_CYC;
        end
        else if (glow_r != 4'h0)
            glow_r <= glow_r - 4'h1;
        else
            gpio_clk_out <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////
    // Serial streaming of running strength
    logic [1:0] sclk_s_r; // Link clock synchroniser
    logic [1:0] csn_s_r; // Select synchroniser
    logic sclk_d_r; // Previous synced clock
    logic [4:0] scnt_r; // Rising edges since select
    logic [7:0] shf_r; // Strength being shifted
    wire rise = sclk_s_r[1] && !sclk_d_r;
    wire fall = !sclk_s_r[1] && sclk_d_r;
    wire stream = scnt_r >= rxq_pkg::SPI_STATUS_BITS;
    wire reload = scnt_r == rxq_pkg::SPI_STATUS_BITS - 5'h01 ||
                  scnt_r == rxq_pkg::SPI_WORD_LAST;
    // Edge finder and word counter, same address every word
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            sclk_s_r <= 2'b00;
            csn_s_r <= 2'b11;
            sclk_d_r <= 1'b0;
            scnt_r <= 5'h00;
            shf_r <= 8'h00;
            spi_miso_out <= 1'b0;
            spi_miso_oe_out <= 1'b0;
        end
        else
        begin
            sclk_s_r <= {sclk_s_r[0], spi_sclk_in};
            csn_s_r <= {csn_s_r[0], spi_csn_in};
            sclk_d_r <= sclk_s_r[1];
            if (csn_s_r[1])
            begin
                scnt_r <= 5'h00;
                spi_miso_oe_out <= 1'b0;
            end
            else if (rise && reload)
            begin
                shf_r <= strength_in;
                scnt_r <= rxq_pkg::SPI_STATUS_BITS;
            end
            else if (rise)
            begin
                scnt_r <= scnt_r + 5'h01;
                if (stream)
                    shf_r <= {shf_r[6:0], 1'b0};
            end
            else if (fall && stream)
            begin
                spi_miso_out <= shf_r[7];
                spi_miso_oe_out <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    chk_expire_abort: assert property (
        expire |=> rx_abort_out && ts_r == rxq_pkg::T_DONE)
        else $error("expiry did not abort");
    chk_and_never: assert property (
        ts_r == rxq_pkg::T_RUN && masks == 3'h0 && !ctrl_r.combine_sel
        |-> !expire)
        else $error("timer expired with no stop condition");
    chk_or_unstoppable: assert property (
        ts_r == rxq_pkg::T_RUN && masks == 3'h0 && ctrl_r.combine_sel
        && rx_active_in |=> ts_r != rxq_pkg::T_HALT)
        else $error("unstoppable timer stopped");
    chk_or_any: assert property (
        ts_r == rxq_pkg::T_RUN && rx_active_in && ctrl_r.combine_sel
        && |(masks & inds) |=> ts_r == rxq_pkg::T_HALT)
        else $error("OR stop missed");
    chk_and_all: assert property (
        ts_r == rxq_pkg::T_RUN && !ctrl_r.combine_sel && masks != 3'h0
        && (masks & inds) != masks |=> ts_r != rxq_pkg::T_HALT)
        else $error("AND stop too early");
    chk_halt_frozen: assert property (
        ts_r == rxq_pkg::T_HALT && rx_active_in |=> $stable(tcnt_r)
        && !rx_abort_out)
        else $error("halted timer moved");
    chk_static_sense: assert property (
        static_m && !cs_r && strength_in > th |=> cs_r)
        else $error("static sense not set");
    chk_pqi_step: assert property (
        rep && !rx_start && pqi_r >= rxq_pkg::PQI_DOWN
        |=> pqi_r == $past(pqi_r) - rxq_pkg::PQI_DOWN)
        else $error("repetition step wrong");
    chk_pqi_valid: assert property (
        pqi_peak_r > preamble_quality_limit && !rx_start |=> preamble_valid_out)
        else $error("preamble valid missed");
    chk_blank_drop: assert property (
        blanked |=> !fifo_wr_out && $stable(gpio_data_out))
        else $error("blanked data passed");
    chk_capture: assert property (
        expire |=> cap_r == $past(strength_in))
        else $error("capture missed at expiry");
    cov_expiry: cover property (ts_r == rxq_pkg::T_RUN ##1 rx_abort_out);
    cov_halt: cover property (ts_r == rxq_pkg::T_RUN
                              ##1 ts_r == rxq_pkg::T_HALT);
    cov_fifo_byte: cover property (fifo_wr_out);
    cov_stream: cover property (spi_miso_oe_out ##1 rise && reload);
endmodule

// ### design/rxq_pkg.sv
// Shared constants and types for the receive quality and timeout block
package rxq_pkg;
    // Register word indexes on the plain register port
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_THRESH = 4'h1;
    localparam logic [3:0] REG_TIMEOUT = 4'h2;
    localparam logic [3:0] REG_STATUS = 4'h3;
    localparam logic [3:0] REG_STRENGTH = 4'h4;
    localparam logic [3:0] REG_QUALITY = 4'h5;
    // Receive data modes
    localparam logic [1:0] MODE_PACKET = 2'h0;
    localparam logic [1:0] MODE_FIFO = 2'h1;
    localparam logic [1:0] MODE_GPIO = 2'h2;
    // Strength coding and detector figures
    localparam int STRENGTH_OFFSET_DBM = -146;
    localparam logic [7:0] CS_HYST_DB = 8'h03;
    localparam logic [7:0] CS_STEP_DB = 8'h06;
    localparam logic [7:0] PQI_UP = 8'h01;
    localparam logic [7:0] PQI_DOWN = 8'h04;
    localparam logic [7:0] PQI_MAX = 8'hff;
    // Reset values
    localparam logic [5:0] SYNC_WORD_LENGTH_RST = 6'h20;
    localparam logic [15:0] TIMEOUT_RST = 16'hffff;
    // Serial stream counts in link clocks
    localparam logic [4:0] SPI_STATUS_BITS = 5'h10;
    localparam logic [4:0] SPI_WORD_LAST = 5'h17;
    // Low phase of the direct data clock
    localparam int GPIO_LOW_NS = 40;
    localparam int CLK_NS = 10;
    localparam logic [3:0] GPIO_LOW_CYC =
        4'((GPIO_LOW_NS + CLK_NS - 1) / CLK_NS);
    // Software control word
    typedef struct packed {
        logic sync_check_on;
        logic [1:0] cs_mode;
        logic blank_en;
        logic [1:0] rx_mode;
        logic pqi_mask;
        logic sync_mask;
        logic cs_mask;
        logic combine_sel;
    } rxq_ctrl_t;
    localparam rxq_ctrl_t CTRL_RST = 10'h204;
    // Thresholds word
    typedef struct packed {
        logic [5:0] sync_word_length;
        logic [2:0] sqi_limit;
        logic [3:0] pqi_limit;
        logic [7:0] strength_th;
    } rxq_thresh_t;
    // Timer states, one hot
    typedef enum logic [3:0] {
        T_IDLE = 4'b0001,
        T_RUN = 4'b0010,
        T_HALT = 4'b0100,
        T_DONE = 4'b1000
    } rxq_tstate_t;
endpackage

// ### dv/rxq_host_model.sv
// Host model: link stream reader and direct data sampler
`timescale 1ns/1ps
module rxq_host_model
(
    // Link pins
    output logic spi_sclk_out,
    output logic spi_csn_out,
    input wire logic spi_miso_in,
    // Direct data pins
    input wire logic gpio_data_in,
    input wire logic gpio_clk_in,
    output logic [7:0] gpio_byte_out
);
    ////////////////////////////////////////////////////////////////////////
    // Idle: link clock stands still, select high
    initial
    begin
        spi_sclk_out = 1'b0;
        spi_csn_out = 1'b1;
        gpio_byte_out = 8'h00;
    end
    // Data is sampled on the rising edge, away from its update edge
    always @(posedge gpio_clk_in)
        gpio_byte_out <= {gpio_byte_out[6:0], gpio_data_in};
    ////////////////////////////////////////////////////////////////////////
    // Frame of n link clocks, keeping the bits after the status phase
    task automatic frame(input int n, output logic [15:0] w);
        w = 16'h0000;
        spi_csn_out = 1'b0;
        for (int i = 1; i <= n; i++)
        begin
            #62.5 spi_sclk_out = 1'b1;
            if (i > 16)
                w = {w[14:0], spi_miso_in};
            #62.5 spi_sclk_out = 1'b0;
        end
        #62.5 spi_csn_out = 1'b1;
    endtask
endmodule

// ### dv/tb_top.sv
// Self-checking bench for the receive quality and timeout block
`timescale 1ns/1ps
module tb_top;
    // Design pins
    logic clk_in, rst_in, wr_s, rd_s, rx_on, abort_s;
    logic bit_s, bit_v, corr_s, corr_sec, sclk, csn;
    logic [3:0] addr;
    logic [31:0] wdata, rdata;
    logic [7:0] strength, f_data, g_byte, last_byte;
    logic [5:0] corr;
    logic miso, miso_oe, f_wr, g_d, g_c, cs, pv, sv, abrt;
    logic [15:0] word;
    // Released line floats high through a pull-up
    wire miso_line = miso_oe ? miso : 1'b1;
    // Tallies
    int failures = 0;
    int total_checks = 0;
    int cyc = 0;
    int abort_at = 0;
    int aborts = 0;
    int writes = 0;
    rxq_top i_rxq_top
    (
        .clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s),
        .reg_rdata_out(rdata), .rx_active_in(rx_on),
        .abort_command_in(abort_s), .strength_in(strength),
        .bit_valid_in(bit_v), .bit_in(bit_s), .sync_corr_valid_in(corr_s),
        .sync_corr_in(corr), .sync_secondary_in(corr_sec),
        .spi_sclk_in(sclk), .spi_csn_in(csn), .spi_miso_out(miso),
        .spi_miso_oe_out(miso_oe), .fifo_wr_out(f_wr),
        .fifo_data_out(f_data), .gpio_data_out(g_d), .gpio_clk_out(g_c),
        .carrier_sense_out(cs), .preamble_valid_out(pv),
        .sync_valid_out(sv), .rx_abort_out(abrt)
    );
    rxq_host_model i_rxq_host_model
    (
        .spi_sclk_out(sclk), .spi_csn_out(csn), .spi_miso_in(miso_line),
        .gpio_data_in(g_d), .gpio_clk_in(g_c), .gpio_byte_out(g_byte)
    );
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    // Stamp abort pulses and catch bytes; the host drains at once
    always @(posedge clk_in)
    begin
        cyc <= cyc + 1;
        if (abrt === 1'b1)
        begin
            aborts <= aborts + 1;
            abort_at <= cyc;
        end
        if (f_wr === 1'b1)
        begin
            writes <= writes + 1;
            last_byte <= f_data;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Register port cycles
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk_in);
        wr_s <= 1'b0;
    endtask
    task automatic rd_chk(input string what, input logic [3:0] a,
        input logic [31:0] m, input logic [31:0] exp);
        @(posedge clk_in);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk_in);
        rd_s <= 1'b0;
        #1 chk(what, exp, rdata & m);
    endtask
    // Receive entry and exit
    task automatic enter(input logic [31:0] ctl);
        wr(rxq_pkg::REG_CTRL, ctl);
        @(posedge clk_in);
        rx_on <= 1'b1;
        tick(2);
    endtask
    task automatic leave();
        @(posedge clk_in);
        rx_on <= 1'b0;
        tick(2);
    endtask
    // One entry under a stop setup; timeout is 5 cycles
    task automatic run(input logic [31:0] ctl, input logic exp);
        int n0;
        int t0;
        wr(rxq_pkg::REG_CTRL, ctl);
        n0 = aborts;
        @(posedge clk_in);
        rx_on <= 1'b1;
        t0 = cyc;
        tick(12);
        chk("abort count", 32'(exp), 32'(aborts - n0));
        if (exp)
            chk("abort cycle", 32'h8, 32'(abort_at - t0));
        rd_chk("timer state", rxq_pkg::REG_STATUS, 32'h78,
            exp ? 32'h40 : 32'h20);
        if (exp)
            rd_chk("capture", rxq_pkg::REG_STRENGTH, 32'hff00, 32'h5000);
        leave();
    endtask
    // Bits MSB first, spaced wider than the direct clock low phase
    task automatic send(input logic [7:0] b, input int n);
        for (int i = n - 1; i >= 0; i--)
        begin
            @(posedge clk_in);
            bit_s <= b[i];
            bit_v <= 1'b1;
            @(posedge clk_in);
            bit_v <= 1'b0;
            tick(6);
        end
    endtask
    task automatic sense(input logic [7:0] s, input logic exp);
        @(posedge clk_in);
        strength <= s;
        tick(3);
        chk("carrier sense", 32'(exp), 32'(cs));
    endtask
    task automatic sync_in(input logic [5:0] v, input logic sec);
        @(posedge clk_in);
        corr <= v;
        corr_sec <= sec;
        corr_s <= 1'b1;
        @(posedge clk_in);
        corr_s <= 1'b0;
        tick(3);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        {wr_s, rd_s, rx_on, abort_s, bit_s, bit_v, corr_s, corr_sec} = '0;
        {corr, addr, wdata} = '0;
        strength = 8'h50;
        rst_in = 1'b1;
        tick(12);
        rst_in <= 1'b0;
        tick(3);
        rd_chk("ctrl", rxq_pkg::REG_CTRL, '1, 32'(rxq_pkg::CTRL_RST));
        rd_chk("thresh", rxq_pkg::REG_THRESH, '1,
            {11'h0, rxq_pkg::SYNC_WORD_LENGTH_RST, 15'h0});
        rd_chk("timeout", rxq_pkg::REG_TIMEOUT, '1, 32'(rxq_pkg::TIMEOUT_RST));
        rd_chk("unmapped", 4'hf, '1, 32'h0);
        wr(rxq_pkg::REG_TIMEOUT, 32'h5);
        wr(rxq_pkg::REG_THRESH, 32'h101140);
        // Carrier sense true, both quality indicators false
        run(32'h001, 1'b1);
        run(32'h000, 1'b0);
        run(32'h002, 1'b0);
        run(32'h204, 1'b1);
        run(32'h20a, 1'b1);
        run(32'h20e, 1'b1);
        run(32'h20b, 1'b0);
        run(32'h20f, 1'b0);
        enter(32'h000);
        strength <= 8'h33;
        abort_s <= 1'b1;
        tick(1);
        abort_s <= 1'b0;
        leave();
        rd_chk("abort capture", rxq_pkg::REG_STRENGTH, '1, 32'h3333);
        $display("timer tests done");
        sense(8'h40, 1'b0);
        sense(8'h41, 1'b1);
        sense(8'h3d, 1'b1);
        sense(8'h3c, 1'b0);
        wr(rxq_pkg::REG_THRESH, 32'h101108);
        for (int m = 1; m <= 3; m++)
        begin
            wr(rxq_pkg::REG_CTRL, 32'(m) << 7);
            sense(8'h10, 1'b0);
            sense(8'h0f + 8'(m * 6), 1'b0);
            sense(8'h10 + 8'(m * 6), 1'b1);
            sense(8'h10, 1'b0);
        end
        $display("carrier sense tests done");
        wr(rxq_pkg::REG_THRESH, 32'h101140);
        enter(32'h050);
        strength <= 8'h30;
        send(8'hc3, 8);
        chk("blanked writes", 32'h0, 32'(writes));
        strength <= 8'h50;
        send(8'ha5, 8);
        chk("fifo writes", 32'h1, 32'(writes));
        chk("fifo byte", 32'ha5, 32'(last_byte));
        leave();
        enter(32'h020);
        send(8'h5a, 8);
        chk("gpio byte", 32'h5a, 32'(g_byte));
        leave();
        $display("data mode tests done");
        enter(32'h000);
        send(8'h0a, 5);
        chk("preamble early", 32'h0, 32'(pv));
        send(8'h01, 1);
        chk("preamble valid", 32'h1, 32'(pv));
        send(8'h2a, 6);
        rd_chk("preamble peak", rxq_pkg::REG_QUALITY, 32'hff, 32'h6);
        leave();
        enter(32'h200);
        strength <= 8'h44;
        sync_in(6'h1d, 1'b0);
        chk("sync early", 32'h0, 32'(sv));
        sync_in(6'h1e, 1'b1);
        chk("sync valid", 32'h1, 32'(sv));
        rd_chk("sync peak", rxq_pkg::REG_QUALITY, 32'h7f00, 32'h5e00);
        rd_chk("sync capture", rxq_pkg::REG_STRENGTH, 32'hff00, 32'h4400);
        leave();
        $display("quality tests done");
        strength <= 8'h61;
        fork
            i_rxq_host_model.frame(32, word);
            begin
                #2600;
                @(posedge clk_in);
                strength <= 8'h9c;
            end
        join
        chk("stream", 32'h619c, 32'(word));
        $display("stream test done");
        print_verdict();
    end
endmodule
